// ===== pkg/vifl_pkg.sv
// Purpose: shared constants and types for the virtual interrupt flag logic
// Assumes: one clock (mclk), asynchronous active-high reset
// Notes:   flag bit positions follow the processor flag register layout
`default_nettype none
package vifl_pkg;
  // register offsets on the plain register port
  localparam logic [7:0]  FLAGS_OFS      = 8'h00;
  localparam logic [7:0]  CTRL_OFS       = 8'h04;
  localparam logic [7:0]  STAT_OFS       = 8'h08;
  // processor flag register field positions
  localparam int          IF_BIT         = 9;
  localparam int          IO_PRIVILEGE_FIELD_LSB       = 12;
  localparam int          VM_BIT         = 17;
  localparam int          VIF_BIT        = 19;
  localparam int          VIP_BIT        = 20;
  localparam int          FIXED_ONE_BIT  = 1;
  // control register field positions
  localparam int          CTRL_VME_BIT   = 0;
  localparam int          CTRL_PE_BIT    = 1;
  // reset values
  localparam logic [31:0] FLAGS_RST      = 32'h0000_0002;
  localparam logic        VME_RST        = 1'b0;
  localparam logic        PE_RST         = 1'b0;
  // privilege field value that switches the virtual flags off
  localparam logic [1:0]  IO_PRIVILEGE_FIELD_TOP       = 2'h3;
  // fault vector and length of the privilege-0 save frame
  localparam logic [7:0]  GP_VECTOR      = 8'h0D;
  localparam logic [3:0]  SAVE_WORDS     = 4'h9;
  localparam logic [3:0]  SAVE_FLAGS_IDX = 4'h2;

  typedef enum logic [2:0] {
    OP_NONE, OP_CLI, OP_STI, OP_FLAG_PUSH_INSTR, OP_FLAG_POP_INSTR, OP_INT_RETURN_INSTR, OP_TASKSW, OP_MODESW
  } vifl_op_t;

  typedef enum logic [1:0] {
    ST_RUN, ST_SAVE, ST_CLEAR
  } vifl_state_t;
endpackage : vifl_pkg
`default_nettype wire

// ===== logic/vifl_req_sync.sv
// Purpose: bring the maskable request pin into mclk and merge the local controller request
// Assumes: lapic_req already runs on mclk
// Notes:   output is a level, held while either source asserts
`default_nettype none
module vifl_req_sync
  import vifl_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  // clock and reset
  input  wire  logic mclk,
  input  wire  logic sys_rst,
  // request sources
  input  wire  logic maskable_int_pin,
  input  wire  logic lapic_req,
  // merged request
  output logic       int_req
);
  typedef struct packed {
    logic [SYNC_STAGES-1:0] sync;
    logic                   req;
  } vifl_sync_st_t;

  vifl_sync_st_t st_reg;
  vifl_sync_st_t st_next;

  if (SYNC_STAGES < 2) begin : g_bad_stages
    $error("vifl_req_sync needs at least two synchroniser stages");
  end

  // only the last stage is read by logic
  always_comb begin
    st_next      = st_reg;
    st_next.sync = {st_reg.sync[SYNC_STAGES-2:0], maskable_int_pin};
    st_next.req  = st_reg.sync[SYNC_STAGES-1] | lapic_req;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign int_req = st_reg.req;
endmodule : vifl_req_sync
`default_nettype wire

// ===== logic/vifl_core.sv
// Purpose: virtual interrupt enable and pending flags for virtual-8086 tasks
// Assumes: instruction and local-controller inputs are on mclk; the request pin is asynchronous
// Notes:
// Functional notes
// - virtual flags live only with extension enable set and privilege field below 3
// - virtual enable flag sits at bit 19 of the flag register
// - virtual pending flag sits at bit 20 of the flag register
// - maskable requests from pin or local controller blocked while real enable clear
// - without the extension, v86 interrupts take the ordinary class 1 path
// - with virtual flags live, disable/enable instructions act on virtual enable only
// - acceptance of maskable interrupts depends on the real enable flag alone
// - with virtual flags live, flag push/pop use virtual enable instead of real
// - pending flag is read by hardware, written only by software
// - interrupt enters privilege 0 and saves nine state words on the stack
// - after saving, clear segments and v86 bit, then start the handler; here handler_start pulses in the same cycle as seg_clear
// - enable instruction checks pending first; sets virtual enable only if clear
// - enable instruction with pending set raises general protection fault
// - both virtual flags set at instruction start raises general protection fault
// - virtual flags untouched in real mode and across real/protected transitions; here a real-mode flag pop or interrupt return loads both from the image
// - these faults are delivered through vector 13
//
// The register offsets and the strobed register port are this design's own decisions.
`default_nettype none
module vifl_core
  import vifl_pkg::*;
(
  // clock and reset
  input  wire  logic        mclk,
  input  wire  logic        sys_rst,
  // register port
  input  wire  logic [7:0]  reg_addr,
  input  wire  logic [31:0] reg_wdata,
  input  wire  logic        reg_wr,
  input  wire  logic        reg_rd,
  output logic [31:0]       reg_rdata,
  // instruction stream
  input  wire  logic        instr_valid,
  input  wire  vifl_op_t    instr_op,
  input  wire  logic [31:0] instr_data,
  output logic              instr_done,
  output logic              core_busy,
  output logic [31:0]       push_data,
  // maskable interrupt requests
  input  wire  logic        maskable_int_pin,
  input  wire  logic        lapic_req,
  input  wire  logic [7:0]  int_vector,
  output logic              int_ack,
  // handler entry
  output logic              stack_wr,
  output logic [3:0]        stack_sel,
  output logic              seg_clear,
  output logic              handler_start,
  output logic [7:0]        handler_vector,
  // fault
  output logic              general_protection_fault,
  output logic [7:0]        fault_vector
);
  typedef struct packed {
    logic [31:0] flags;
    logic        mode_extension_enable;
    logic        pe;
    vifl_state_t state;
    logic [3:0]  save_idx;
    logic [3:0]  sel;
    logic [7:0]  vector;
    logic [7:0]  fault_cnt;
    logic [31:0] push_data;
    logic [31:0] rdata;
    logic        done;
    logic        ack;
    logic        stack_wr;
    logic        seg_clear;
    logic        handler_start;
    logic        gp_fault;
  } vifl_st_t;

  vifl_st_t st_reg;
  vifl_st_t st_next;
  logic     int_req;
  logic     virt_active;
  logic     both_set;
  logic     int_take;

  vifl_req_sync #(
    .SYNC_STAGES (2)
  ) u_req_sync (
    .mclk             (mclk),
    .sys_rst          (sys_rst),
    .maskable_int_pin (maskable_int_pin),
    .lapic_req        (lapic_req),
    .int_req          (int_req)
  );

  // virtual flags only mean something inside a protected-mode v86 task
  assign virt_active = st_reg.mode_extension_enable && (st_reg.flags[IO_PRIVILEGE_FIELD_LSB +: 2] != IO_PRIVILEGE_FIELD_TOP)
                       && st_reg.flags[VM_BIT] && st_reg.pe;
  assign both_set    = st_reg.flags[VIF_BIT] && st_reg.flags[VIP_BIT];
  // real enable alone decides; instructions win the cycle, a held request waits
  assign int_take    = int_req && st_reg.flags[IF_BIT] && !instr_valid;

  always_comb begin
    st_next               = st_reg;
    st_next.done          = 1'b0;
    st_next.ack           = 1'b0;
    st_next.stack_wr      = 1'b0;
    st_next.seg_clear     = 1'b0;
    st_next.handler_start = 1'b0;
    st_next.gp_fault      = 1'b0;
    st_next.rdata         = '0;

    unique case (st_reg.state)
      ST_RUN: begin
        if (instr_valid) begin
          st_next.done = 1'b1;
          if (virt_active && both_set) begin
            st_next.gp_fault = 1'b1;
          end else begin
            unique case (instr_op)
              OP_CLI: begin
                if (virt_active) begin
                  st_next.flags[VIF_BIT] = 1'b0;
                end else begin
                  st_next.flags[IF_BIT] = 1'b0;
                end
              end
              OP_STI: begin
                if (!virt_active) begin
                  st_next.flags[IF_BIT] = 1'b1;
                end else if (st_reg.flags[VIP_BIT]) begin
                  // fault leaves virtual enable as it was so the retry sees it clear
                  st_next.gp_fault = 1'b1;
                end else begin
                  st_next.flags[VIF_BIT] = 1'b1;
                end
              end
              OP_FLAG_PUSH_INSTR: begin
                st_next.push_data = st_reg.flags;
                if (virt_active) begin
                  st_next.push_data[IF_BIT] = st_reg.flags[VIF_BIT];
                end
              end
              OP_FLAG_POP_INSTR: begin
                if (virt_active) begin
                  // privileged fields and the real enable are kept
                  st_next.flags = instr_data;
                  st_next.flags[IF_BIT]         = st_reg.flags[IF_BIT];
                  st_next.flags[IO_PRIVILEGE_FIELD_LSB +: 2]  = st_reg.flags[IO_PRIVILEGE_FIELD_LSB +: 2];
                  st_next.flags[VM_BIT]         = st_reg.flags[VM_BIT];
                  st_next.flags[VIP_BIT]        = st_reg.flags[VIP_BIT];
                  st_next.flags[VIF_BIT]        = instr_data[IF_BIT];
                end else begin
                  st_next.flags         = instr_data;
                  st_next.flags[VM_BIT] = st_reg.flags[VM_BIT];
                end
                st_next.flags[FIXED_ONE_BIT] = 1'b1;
              end
              OP_INT_RETURN_INSTR, OP_TASKSW: begin
                // a full image load is a software write of the pending flag
                st_next.flags                = instr_data;
                st_next.flags[FIXED_ONE_BIT] = 1'b1;
              end
              OP_MODESW: begin
                st_next.pe            = !st_reg.pe;
                st_next.flags[VM_BIT] = 1'b0;
              end
              OP_NONE: begin
                st_next.done = 1'b1;
              end
            endcase
          end
          if (st_next.gp_fault) begin
            st_next.fault_cnt = st_reg.fault_cnt + 8'h01;
          end
        end else if (int_take) begin
          st_next.ack    = 1'b1;
          st_next.vector = int_vector;
          if (st_reg.pe && st_reg.flags[VM_BIT]) begin
            // same frame whether or not the extension is on
            st_next.state     = ST_SAVE;
            st_next.save_idx  = '0;
            st_next.push_data = st_reg.flags;
          end else begin
            st_next.handler_start = 1'b1;
          end
        end
      end
      ST_SAVE: begin
        st_next.stack_wr = 1'b1;
        st_next.sel      = st_reg.save_idx;
        st_next.save_idx = st_reg.save_idx + 4'h1;
        if (st_reg.save_idx == SAVE_WORDS - 4'h1) begin
          st_next.state = ST_CLEAR;
        end
      end
      ST_CLEAR: begin
        st_next.seg_clear     = 1'b1;
        st_next.flags[VM_BIT] = 1'b0;
        st_next.handler_start = 1'b1;
        st_next.state         = ST_RUN;
      end
    endcase

    if (reg_wr) begin
      unique case (reg_addr)
        FLAGS_OFS: begin
          st_next.flags                = reg_wdata;
          st_next.flags[FIXED_ONE_BIT] = 1'b1;
        end
        CTRL_OFS: begin
          st_next.mode_extension_enable = reg_wdata[CTRL_VME_BIT];
          st_next.pe  = reg_wdata[CTRL_PE_BIT];
        end
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        FLAGS_OFS: st_next.rdata = st_reg.flags;
        CTRL_OFS:  st_next.rdata = {30'h0, st_reg.pe, st_reg.mode_extension_enable};
        STAT_OFS:  st_next.rdata = {12'h0, (st_reg.state != ST_RUN), virt_active, both_set, 1'b0,
                                    st_reg.vector, st_reg.fault_cnt};
        default:   st_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg       <= '0;
      st_reg.flags <= FLAGS_RST;
      st_reg.mode_extension_enable   <= VME_RST;
      st_reg.pe    <= PE_RST;
      st_reg.state <= ST_RUN;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata                = st_reg.rdata;
  assign instr_done               = st_reg.done;
  assign core_busy                = (st_reg.state != ST_RUN);
  assign push_data                = st_reg.push_data;
  assign int_ack                  = st_reg.ack;
  assign stack_wr                 = st_reg.stack_wr;
  assign stack_sel                = st_reg.sel;
  assign seg_clear                = st_reg.seg_clear;
  assign handler_start            = st_reg.handler_start;
  assign handler_vector           = st_reg.vector;
  assign general_protection_fault = st_reg.gp_fault;
  assign fault_vector             = GP_VECTOR;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  logic run_instr;
  assign run_instr = instr_valid && (st_reg.state == ST_RUN) && !reg_wr;

  chk_sti_pending_fault: assert property (
    run_instr && instr_op == OP_STI && virt_active && st_reg.flags[VIP_BIT]
    |=> general_protection_fault && $stable(st_reg.flags[VIF_BIT]))
    else $error("enable with pending set did not fault cleanly");
  chk_sti_sets_vif: assert property (
    run_instr && instr_op == OP_STI && virt_active && !st_reg.flags[VIP_BIT]
    |=> st_reg.flags[VIF_BIT] && !general_protection_fault && $stable(st_reg.flags[IF_BIT]))
    else $error("enable with pending clear did not set virtual enable");
  chk_cli_virtual: assert property (
    run_instr && instr_op == OP_CLI && virt_active && !both_set
    |=> !st_reg.flags[VIF_BIT] && $stable(st_reg.flags[IF_BIT]))
    else $error("disable touched the real enable");
  chk_both_set_fault: assert property (
    run_instr && virt_active && both_set |=> general_protection_fault)
    else $error("both virtual flags set without fault");
  chk_flag_push_instr_image: assert property (
    run_instr && instr_op == OP_FLAG_PUSH_INSTR && virt_active && !both_set
    |=> push_data[IF_BIT] == $past(st_reg.flags[VIF_BIT]))
    else $error("flag push did not carry virtual enable");
  chk_ack_real_if: assert property (
    int_ack |-> $past(st_reg.flags[IF_BIT]))
    else $error("interrupt accepted with real enable clear");
  chk_save_frame: assert property (
    $rose(stack_wr) |-> stack_wr [*8] ##1 stack_wr ##1 (!stack_wr && seg_clear && handler_start))
    else $error("save frame is not nine words then segment clear");
  chk_vip_no_hw_write: assert property (
    run_instr && (instr_op inside {OP_CLI, OP_STI, OP_FLAG_PUSH_INSTR, OP_FLAG_POP_INSTR, OP_MODESW})
    |=> $stable(st_reg.flags[VIP_BIT]))
    else $error("hardware changed the pending flag");
  chk_modesw_keeps: assert property (
    run_instr && instr_op == OP_MODESW
    |=> $stable(st_reg.flags[VIF_BIT]) && $stable(st_reg.flags[VIP_BIT]))
    else $error("mode transition changed the virtual flags");
  chk_clear_vm: assert property (
    seg_clear |-> !st_reg.flags[VM_BIT] && fault_vector == GP_VECTOR)
    else $error("handler entry left the v86 bit set");

  cov_sti_fault:  cover property (run_instr && instr_op == OP_STI && virt_active ##1 general_protection_fault);
  cov_v86_entry:  cover property ($rose(stack_wr) ##[9:12] handler_start);
  cov_flag_pop_instr_both:  cover property (run_instr && instr_op == OP_FLAG_POP_INSTR ##1 both_set && virt_active);
endmodule : vifl_core
`default_nettype wire

// ===== tb/vifl_irq_model.sv
// Purpose: far side of the core: maskable request source (pin or local controller)
// Assumes: requests are levels; the core acknowledges each taken request with a one-cycle pulse
// Notes:   a request is held until the acknowledge is sampled, then dropped
`default_nettype none
module vifl_irq_model (
  // clock and reset
  input  wire  logic       mclk,
  input  wire  logic       sys_rst,
  // answer from the core
  input  wire  logic       int_ack,
  // request lines
  output logic             maskable_int_pin,
  output logic             lapic_req,
  output logic [7:0]       int_vector
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    maskable_int_pin = 1'b0;
    lapic_req        = 1'b0;
    int_vector       = 8'h00;
  end

  // hold until taken; vector no longer valid after, so show its inverse
  always @(posedge mclk) begin
    if (int_ack === 1'b1) begin
      maskable_int_pin <= 1'b0;
      lapic_req        <= 1'b0;
      int_vector       <= ~int_vector;
    end
  end

  task automatic fire(input logic use_pin, input logic [7:0] vec);
    @(posedge mclk);
    int_vector <= vec;
    if (use_pin) maskable_int_pin <= 1'b1;
    else lapic_req <= 1'b1;
  endtask : fire
endmodule : vifl_irq_model
`default_nettype wire

// ===== tb/tb_vifl_core.sv
// Purpose: self-checking bench for the virtual interrupt flag core
// Assumes: register port and instruction stream driven on rising edges
// Notes:   the bench plays monitor software by rewriting flag images
`default_nettype none
module tb_vifl_core;
  timeunit 1ns;
  timeprecision 1ns;
  import vifl_pkg::*;

  logic        mclk, sys_rst, reg_wr, reg_rd, instr_valid, instr_done, core_busy;
  logic [7:0]  reg_addr, int_vector, handler_vector, fault_vector;
  logic [31:0] reg_wdata, reg_rdata, instr_data, push_data, rd;
  vifl_op_t    instr_op;
  logic        maskable_int_pin, lapic_req, int_ack, stack_wr, seg_clear, handler_start;
  logic        general_protection_fault;
  logic [3:0]  stack_sel;
  int          err_count, checks_done;

  vifl_core u_vifl_core (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_data(instr_data), .instr_done(instr_done), .core_busy(core_busy),
    .push_data(push_data), .maskable_int_pin(maskable_int_pin), .lapic_req(lapic_req),
    .int_vector(int_vector), .int_ack(int_ack), .stack_wr(stack_wr), .stack_sel(stack_sel),
    .seg_clear(seg_clear), .handler_start(handler_start), .handler_vector(handler_vector),
    .general_protection_fault(general_protection_fault), .fault_vector(fault_vector));

  vifl_irq_model u_vifl_irq_model (.mclk(mclk), .sys_rst(sys_rst), .int_ack(int_ack),
    .maskable_int_pin(maskable_int_pin), .lapic_req(lapic_req), .int_vector(int_vector));

  always #5 mclk = ~mclk;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read

  // done and fault are looked at in the single cycle they stand
  task automatic instr(input vifl_op_t op, input logic [31:0] d, input logic fault_exp);
    @(posedge mclk);
    instr_valid <= 1'b1; instr_op <= op; instr_data <= d;
    @(posedge mclk);
    instr_valid <= 1'b0;
    #1;
    chk("done", 32'h1, {31'h0, instr_done});
    chk("fault", {31'h0, fault_exp}, {31'h0, general_protection_fault});
  endtask : instr

  task automatic flags_is(input logic [31:0] exp);
    reg_read(FLAGS_OFS, rd);
    chk("flags", exp, rd);
  endtask : flags_is

  task automatic entry(input logic [7:0] vec);
    int n;
    int k;
    n = 0;
    for (k = 0; k < 60 && int_ack !== 1'b1; k++) begin @(posedge mclk); #1; end
    chk("ack", 32'h1, {31'h0, int_ack});
    for (k = 0; k < 30 && handler_start !== 1'b1; k++) begin
      @(posedge mclk); #1;
      if (stack_wr === 1'b1) begin
        chk("sel", n, {28'h0, stack_sel});
        chk("busy", 32'h1, {31'h0, core_busy});
        n++;
      end
    end
    chk("words", 32'h9, n);
    chk("segclr", 32'h1, {31'h0, seg_clear});
    chk("idle", 32'h0, {31'h0, core_busy});
    chk("hvec", {24'h0, vec}, {24'h0, handler_vector});
  endtask : entry

  task automatic t_reset;
    flags_is(32'h0000_0002);
    reg_read(CTRL_OFS, rd);
    chk("ctrl", 32'h0, rd);
    reg_read(8'h0C, rd);
    chk("unmapped", 32'h0, rd);
    $display("end t_reset");
  endtask : t_reset

  // without the extension a v86 request takes the plain save-and-enter path
  task automatic t_class1;
    reg_write(CTRL_OFS, 32'h0000_0002);
    reg_write(FLAGS_OFS, 32'h0002_0202);
    u_vifl_irq_model.fire(1'b1, 8'h21);
    entry(8'h21);
    flags_is(32'h0000_0202);
    $display("end t_class1");
  endtask : t_class1

  task automatic t_virtual;
    reg_write(CTRL_OFS, 32'h0000_0003);
    reg_write(FLAGS_OFS, 32'h0002_3202);
    reg_read(STAT_OFS, rd);
    chk("act_iopl3", 32'h0, {31'h0, rd[18]});
    reg_write(FLAGS_OFS, 32'h0002_0202);
    reg_read(STAT_OFS, rd);
    chk("act", 32'h1, {31'h0, rd[18]});
    instr(OP_STI, 32'h0, 1'b0);
    flags_is(32'h000A_0202);
    instr(OP_CLI, 32'h0, 1'b0);
    flags_is(32'h0002_0202);
    instr(OP_FLAG_PUSH_INSTR, 32'h0, 1'b0);
    chk("push_if", 32'h0, {31'h0, push_data[IF_BIT]});
    instr(OP_FLAG_POP_INSTR, 32'h0000_0200, 1'b0);
    flags_is(32'h000A_0202);
    $display("end t_virtual");
  endtask : t_virtual

  // entry with virtual enable clear, monitor defers, enable faults, monitor services
  task automatic t_defer;
    reg_write(FLAGS_OFS, 32'h0002_0202);
    u_vifl_irq_model.fire(1'b0, 8'hFF);
    entry(8'hFF);
    flags_is(32'h0000_0202);
    instr(OP_INT_RETURN_INSTR, 32'h0012_0202, 1'b0);
    instr(OP_STI, 32'h0, 1'b1);
    chk("fvec", {24'h0, GP_VECTOR}, {24'h0, fault_vector});
    flags_is(32'h0012_0202);
    instr(OP_INT_RETURN_INSTR, 32'h000A_0202, 1'b0);
    flags_is(32'h000A_0202);
    instr(OP_INT_RETURN_INSTR, 32'h001A_0202, 1'b0);
    instr(OP_CLI, 32'h0, 1'b1);
    $display("end t_defer");
  endtask : t_defer

  // virtual enable set but real enable clear: the request must wait
  task automatic t_mask;
    reg_write(FLAGS_OFS, 32'h000A_0002);
    u_vifl_irq_model.fire(1'b0, 8'h00);
    repeat (20) begin
      @(posedge mclk); #1;
      chk("blocked", 32'h0, {31'h0, int_ack});
    end
    reg_write(FLAGS_OFS, 32'h0002_0202);
    entry(8'h00);
    $display("end t_mask");
  endtask : t_mask

  task automatic t_mode;
    reg_write(CTRL_OFS, 32'h0000_0001);
    reg_write(FLAGS_OFS, 32'h0018_0202);
    instr(OP_MODESW, 32'h0, 1'b0);
    flags_is(32'h0018_0202);
    reg_read(CTRL_OFS, rd);
    chk("pe", 32'h3, rd);
    instr(OP_MODESW, 32'h0, 1'b0);
    flags_is(32'h0018_0202);
    $display("end t_mode");
  endtask : t_mode

  initial begin
    mclk = 1'b0; sys_rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00;
    reg_wdata = 32'h0; instr_valid = 1'b0; instr_op = OP_NONE; instr_data = 32'h0;
    err_count = 0; checks_done = 0;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset();
    t_class1();
    t_virtual();
    t_defer();
    t_mask();
    t_mode();
    stop_test();
  end

  // whole run is well under two hundred cycles; this is far beyond it
  initial begin
    #200us;
    err_count++;
    stop_test();
  end
endmodule : tb_vifl_core
`default_nettype wire
